// *** design/fau_pkg.sv ***
// Constants, opcodes and types of the floating arithmetic unit
package fau_pkg;

  // ----------------------------------------
  // Formats
  // ----------------------------------------
  localparam int MANT_W     = 48;
  localparam int EXP_W      = 18;
  localparam int SGL_KEEP   = 31;
  localparam int SGL_MANT   = 24;
  localparam int SGL_EXP_W  = 8;
  localparam int DBL_EXP_W  = 16;
  localparam int RND_TEST   = 25;
  localparam int RND_ADD    = 24;
  localparam int INT_POINT  = 31;
  localparam int CNT_W      = 6;

  // ----------------------------------------
  // Limits
  // ----------------------------------------
  localparam logic signed [EXP_W-1:0] EXP_MAX     = 18'sd32639;
  localparam logic signed [EXP_W-1:0] EXP_MIN     = -18'sd32896;
  localparam logic signed [EXP_W-1:0] SGL_EXP_MAX = 18'sd127;
  localparam logic signed [EXP_W-1:0] SGL_EXP_MIN = -18'sd128;
  localparam logic signed [EXP_W-1:0] WORD_LIM    = 18'sd30;
  localparam logic signed [EXP_W-1:0] HALF_LIM    = 18'sd15;
  localparam logic signed [EXP_W-1:0] EXP_ONE     = 18'sd1;

  // ----------------------------------------
  // Opcodes with the accumulator select bit cleared
  // ----------------------------------------
  localparam logic [7:0] MEM_SEL_MASK = 8'h02;
  localparam logic [7:0] GEN_SEL_MASK = 8'h08;
  localparam logic [7:0] OP_LOAD   = 8'h00;
  localparam logic [7:0] OP_WLOAD  = 8'h01;
  localparam logic [7:0] OP_CMP    = 8'h04;
  localparam logic [7:0] OP_WCMP   = 8'h05;
  localparam logic [7:0] OP_STORE  = 8'h08;
  localparam logic [7:0] OP_WSTORE = 8'h09;
  localparam logic [7:0] OP_SUM    = 8'h0c;
  localparam logic [7:0] OP_WSUM   = 8'h0d;
  localparam logic [7:0] OP_DIFF   = 8'h10;
  localparam logic [7:0] OP_WDIFF  = 8'h11;
  localparam logic [7:0] OP_PROD   = 8'h14;
  localparam logic [7:0] OP_WPROD  = 8'h15;
  localparam logic [7:0] OP_QUOT   = 8'h18;
  localparam logic [7:0] OP_WQUOT  = 8'h19;
  localparam logic [7:0] OP_NEG    = 8'h40;
  localparam logic [7:0] OP_R2H    = 8'h41;
  localparam logic [7:0] OP_H2R    = 8'h42;
  localparam logic [7:0] OP_R2W    = 8'h43;
  localparam logic [7:0] OP_W2R    = 8'h45;
  localparam logic [7:0] OP_WIDEN  = 8'h46;
  localparam logic [7:0] OP_ROUND  = 8'h47;
  localparam logic [7:0] OP_WNEG   = 8'h64;

  typedef enum logic [1:0] {FAU_IDLE, FAU_EXEC, FAU_DIVIDE} fau_state_t;

  typedef enum logic [2:0] {
    FAU_EXC_NONE, FAU_EXC_OVER, FAU_EXC_UNDER, FAU_EXC_STORE, FAU_EXC_DIV0, FAU_EXC_INT
  } fau_exc_t;

endpackage

// *** design/fau_normalize.sv ***
// Result normalizer of the floating arithmetic unit
`timescale 1ns/1ns
module fau_normalize
  import fau_pkg::*;
(
  input  wire logic [MANT_W:0]         mant_in,
  input  wire logic signed [EXP_W-1:0] exp_in,
  output logic [MANT_W-1:0]            mant_out,
  output logic signed [EXP_W-1:0]      exp_out
);

  logic [MANT_W-1:0] m;
  logic [6:0]        sh;
  logic              found;

  always_comb
  begin
    m = mant_in[MANT_W-1:0];
    sh = 7'h00;
    found = 1'b0;
    for (int i = MANT_W - 2; i >= 0; i--)
    begin
      if (!found && (m[i] != m[MANT_W-1]))
      begin
        found = 1'b1;
        sh = 7'(MANT_W - 2 - i);
      end
    end
    if (mant_in[MANT_W] != mant_in[MANT_W-1])
    begin
      mant_out = mant_in[MANT_W:1];
      exp_out = exp_in + EXP_ONE;
    end
    else if (!found && !m[MANT_W-1])
    begin
      // Zero carries exponent zero so compares see a clean value
      mant_out = '0;
      exp_out = '0;
    end
    else
    begin
      if (!found)
        sh = 7'(MANT_W - 1);
      mant_out = m << sh;
      exp_out = exp_in - EXP_W'(sh);
    end
  end

endmodule

// *** design/fau_core.sv ***
// Floating arithmetic unit with two accumulators
`timescale 1ns/1ns
module fau_core
  import fau_pkg::*;
(
  input  wire logic                clk,
  input  wire logic                reset,
  input  wire logic                op_valid,
  input  wire logic [7:0]          op_code,
  input  wire logic [63:0]         mem_operand,
  input  wire logic [31:0]         int_operand,
  input  wire logic                real_fault_enable,
  output logic                     busy,
  output logic                     op_done,
  output logic                     store_valid,
  output logic [63:0]              store_data,
  output logic                     int_valid,
  output logic [31:0]              int_result,
  output logic                     result_valid,
  output logic [MANT_W-1:0]        result_mant,
  output logic signed [EXP_W-1:0]  result_exp,
  output logic                     overflow_key,
  output logic                     negative_flag,
  output logic                     zero_match_flag,
  output logic                     real_fault,
  output fau_exc_t                 exc_code
);

  // ----------------------------------------
  // State
  // ----------------------------------------
  fau_state_t               state, next_state;
  logic [7:0]               op_reg, next_op;
  logic [63:0]              mem_reg, next_mem;
  logic [31:0]              int_reg, next_int;
  logic [MANT_W-1:0]        acc_mant [0:1];
  logic [MANT_W-1:0]        next_acc_mant [0:1];
  logic signed [EXP_W-1:0]  acc_exp [0:1];
  logic signed [EXP_W-1:0]  next_acc_exp [0:1];
  logic [MANT_W:0]          div_rem, next_rem, div_den, next_den, div_quo, next_quo;
  logic [CNT_W-1:0]         div_cnt, next_cnt;
  logic                     div_neg, next_div_neg;
  logic                     next_busy, next_done, next_store_valid, next_int_valid;
  logic                     next_result_valid, next_c, next_neg, next_zero, next_fault;
  logic [63:0]              next_store_data;
  logic [31:0]              next_int_result;
  logic [MANT_W-1:0]        next_result_mant;
  logic signed [EXP_W-1:0]  next_result_exp;
  fau_exc_t                 next_exc, exc;
  logic                     commit, use_norm, set_c;

  // ----------------------------------------
  // Operand decode
  // ----------------------------------------
  logic [7:0]               cur_key;
  logic                     cur_sel, cur_dbl;
  logic [MANT_W-1:0]        a_m, b_m, norm_m;
  logic signed [EXP_W-1:0]  a_e, b_e, norm_e, norm_e_in;
  logic [MANT_W:0]          norm_in, ax, bx, sum_val, mag_a, mag_b;
  logic signed [EXP_W-1:0]  ed, big_e;
  logic [6:0]               sh;
  logic [2*MANT_W-1:0]      prod;
  logic [MANT_W-1:0]        int_shift;
  logic [5:0]               int_sh;

  assign cur_sel = op_reg[6] ? op_reg[3] : op_reg[1];
  assign cur_key = op_reg[6] ? (op_reg & ~GEN_SEL_MASK) : (op_reg & ~MEM_SEL_MASK);
  assign cur_dbl = op_reg[6] ? (cur_key == OP_WNEG) : op_reg[0];
  assign a_m = acc_mant[cur_sel];
  assign a_e = acc_exp[cur_sel];
  assign b_m = cur_dbl ? mem_reg[63:DBL_EXP_W]
                       : {mem_reg[31:SGL_EXP_W], {(MANT_W-SGL_MANT){1'b0}}};
  assign b_e = cur_dbl ? EXP_W'($signed(mem_reg[DBL_EXP_W-1:0]))
                       : EXP_W'($signed(mem_reg[SGL_EXP_W-1:0]));

  // ----------------------------------------
  // Arithmetic paths feeding the normalizer
  // ----------------------------------------
  always_comb
  begin
    ax = {a_m[MANT_W-1], a_m};
    bx = {b_m[MANT_W-1], b_m};
    if (cur_key == OP_DIFF || cur_key == OP_WDIFF || cur_key == OP_CMP || cur_key == OP_WCMP)
      bx = -bx;
    ed = a_e - b_e;
    big_e = a_e;
    if (ed >= 0)
    begin
      sh = (ed > EXP_W'(MANT_W)) ? 7'(MANT_W) : 7'(ed);
      bx = $signed(bx) >>> sh;
    end
    else
    begin
      sh = (-ed > EXP_W'(MANT_W)) ? 7'(MANT_W) : 7'(-ed);
      ax = $signed(ax) >>> sh;
      big_e = b_e;
    end
    sum_val = ax + bx;
    prod = $signed(a_m) * $signed(b_m);
    mag_a = a_m[MANT_W-1] ? -{1'b1, a_m} : {1'b0, a_m};
    mag_b = b_m[MANT_W-1] ? -{1'b1, b_m} : {1'b0, b_m};
    int_sh = 6'(MANT_W - 1) - 6'(a_e);
    int_shift = $signed(a_m) >>> int_sh;
    norm_in = sum_val;
    norm_e_in = big_e;
    if (state == FAU_DIVIDE)
    begin
      // Dividend was halved so the quotient stays below one
      norm_in = div_neg ? -div_quo : div_quo;
      norm_e_in = a_e - b_e + EXP_ONE;
    end
    else if (cur_key == OP_PROD || cur_key == OP_WPROD)
    begin
      norm_in = prod[2*MANT_W-1:MANT_W-1];
      norm_e_in = a_e + b_e;
    end
    else if (cur_key == OP_NEG || cur_key == OP_WNEG)
    begin
      norm_in = -{a_m[MANT_W-1], a_m};
      norm_e_in = a_e;
    end
    else if (cur_key == OP_ROUND)
    begin
      norm_in = {a_m[MANT_W-1], a_m};
      if (a_m[MANT_W-RND_TEST])
      begin
        norm_in[MANT_W-RND_TEST] = 1'b0;
        norm_in = norm_in + ((MANT_W+1)'(1) << (MANT_W - RND_ADD));
      end
      norm_e_in = a_e;
    end
    else if (cur_key == OP_W2R || cur_key == OP_H2R)
    begin
      norm_in = cur_key == OP_W2R
              ? {int_reg[31], int_reg, {(MANT_W-32){1'b0}}}
              : {{17{int_reg[31]}}, int_reg[31:16], {(MANT_W-32){1'b0}}};
      norm_e_in = EXP_W'(INT_POINT);
    end
  end

  fau_normalize u_norm
  (
    .mant_in  (norm_in),
    .exp_in   (norm_e_in),
    .mant_out (norm_m),
    .exp_out  (norm_e)
  );

  // ----------------------------------------
  // Sequencing and write back
  // ----------------------------------------
  always_comb
  begin
    next_state = state;
    next_op = op_reg;
    next_mem = mem_reg;
    next_int = int_reg;
    next_acc_mant = acc_mant;
    next_acc_exp = acc_exp;
    next_rem = div_rem;
    next_den = div_den;
    next_quo = div_quo;
    next_cnt = div_cnt;
    next_div_neg = div_neg;
    next_busy = busy;
    next_done = 1'b0;
    next_store_valid = 1'b0;
    next_store_data = store_data;
    next_int_valid = 1'b0;
    next_int_result = int_result;
    next_result_valid = 1'b0;
    next_result_mant = result_mant;
    next_result_exp = result_exp;
    next_c = overflow_key;
    next_neg = negative_flag;
    next_zero = zero_match_flag;
    next_fault = 1'b0;
    next_exc = exc_code;
    exc = FAU_EXC_NONE;
    commit = 1'b0;
    use_norm = 1'b0;
    set_c = 1'b0;
    case (state)
      FAU_IDLE:
      begin
        if (op_valid)
        begin
          next_op = op_code;
          next_mem = mem_operand;
          next_int = int_operand;
          next_busy = 1'b1;
          next_state = FAU_EXEC;
        end
      end
      FAU_EXEC:
      begin
        commit = 1'b1;
        case (cur_key)
          OP_LOAD, OP_WLOAD:
          begin
            next_acc_mant[cur_sel] = b_m;
            next_acc_exp[cur_sel] = b_e;
          end
          OP_CMP, OP_WCMP:
          begin
            next_neg = sum_val[MANT_W];
            next_zero = (sum_val == '0);
          end
          OP_STORE:
          begin
            set_c = 1'b1;
            if (a_e > SGL_EXP_MAX || a_e < SGL_EXP_MIN)
              exc = FAU_EXC_STORE;
            else
            begin
              next_store_valid = 1'b1;
              next_store_data = {32'h0, a_m[MANT_W-1 -: SGL_MANT], a_e[SGL_EXP_W-1:0]};
            end
          end
          OP_WSTORE:
          begin
            next_store_valid = 1'b1;
            next_store_data = {a_m, a_e[DBL_EXP_W-1:0]};
          end
          OP_QUOT, OP_WQUOT:
          begin
            if (b_m == '0)
            begin
              set_c = 1'b1;
              exc = FAU_EXC_DIV0;
            end
            else
            begin
              commit = 1'b0;
              next_rem = {1'b0, mag_a[MANT_W:1]};
              next_den = mag_b;
              next_quo = '0;
              next_cnt = CNT_W'(MANT_W);
              next_div_neg = a_m[MANT_W-1] ^ b_m[MANT_W-1];
              next_state = FAU_DIVIDE;
            end
          end
          OP_R2W, OP_R2H:
          begin
            set_c = 1'b1;
            if (a_e > (cur_key == OP_R2W ? WORD_LIM : HALF_LIM))
              exc = FAU_EXC_INT;
            else
            begin
              next_int_valid = 1'b1;
              if (a_e < 0)
                next_int_result = {32{a_m[MANT_W-1]}};
              else
                next_int_result = cur_key == OP_R2W ? int_shift[31:0]
                                                    : {int_shift[15:0], 16'h0};
            end
          end
          OP_WIDEN:
            next_acc_mant[cur_sel] = {a_m[MANT_W-1 -: SGL_KEEP], {(MANT_W-SGL_KEEP){1'b0}}};
          OP_SUM, OP_WSUM, OP_DIFF, OP_WDIFF, OP_PROD, OP_WPROD,
          OP_NEG, OP_WNEG, OP_ROUND, OP_W2R, OP_H2R:
          begin
            use_norm = 1'b1;
            set_c = 1'b1;
          end
          default:
            ;
        endcase
      end
      FAU_DIVIDE:
      begin
        if (div_cnt == '0)
        begin
          commit = 1'b1;
          use_norm = 1'b1;
          set_c = 1'b1;
        end
        else
        begin
          next_cnt = div_cnt - CNT_W'(1);
          if (div_rem >= div_den)
          begin
            next_rem = (div_rem - div_den) << 1;
            next_quo = {div_quo[MANT_W-1:0], 1'b1};
          end
          else
          begin
            next_rem = div_rem << 1;
            next_quo = {div_quo[MANT_W-1:0], 1'b0};
          end
        end
      end
      default:
        next_state = FAU_IDLE;
    endcase
    if (use_norm)
    begin
      if (norm_e > EXP_MAX)
        exc = FAU_EXC_OVER;
      else if (norm_e < EXP_MIN)
        exc = FAU_EXC_UNDER;
      // Single results keep only the register's single mantissa width
      next_result_mant = cur_dbl ? norm_m
                       : {norm_m[MANT_W-1 -: SGL_KEEP], {(MANT_W-SGL_KEEP){1'b0}}};
      next_result_exp = norm_e;
      next_result_valid = 1'b1;
      next_acc_mant[cur_sel] = next_result_mant;
      next_acc_exp[cur_sel] = norm_e;
    end
    if (commit)
    begin
      next_state = FAU_IDLE;
      next_busy = 1'b0;
      next_done = 1'b1;
      next_exc = exc;
      if (set_c)
        next_c = (exc != FAU_EXC_NONE);
      next_fault = (exc != FAU_EXC_NONE) && real_fault_enable;
    end
  end

  always_ff @(posedge clk or posedge reset)
  begin
    if (reset)
    begin
      state <= FAU_IDLE;
      op_reg <= '0;
      mem_reg <= '0;
      int_reg <= '0;
      acc_mant <= '{default: '0};
      acc_exp <= '{default: '0};
      div_rem <= '0;
      div_den <= '0;
      div_quo <= '0;
      div_cnt <= '0;
      div_neg <= 1'b0;
      busy <= 1'b0;
      op_done <= 1'b0;
      store_valid <= 1'b0;
      store_data <= '0;
      int_valid <= 1'b0;
      int_result <= '0;
      result_valid <= 1'b0;
      result_mant <= '0;
      result_exp <= '0;
      overflow_key <= 1'b0;
      negative_flag <= 1'b0;
      zero_match_flag <= 1'b0;
      real_fault <= 1'b0;
      exc_code <= FAU_EXC_NONE;
    end
    else
    begin
      state <= next_state;
      op_reg <= next_op;
      mem_reg <= next_mem;
      int_reg <= next_int;
      acc_mant <= next_acc_mant;
      acc_exp <= next_acc_exp;
      div_rem <= next_rem;
      div_den <= next_den;
      div_quo <= next_quo;
      div_cnt <= next_cnt;
      div_neg <= next_div_neg;
      busy <= next_busy;
      op_done <= next_done;
      store_valid <= next_store_valid;
      store_data <= next_store_data;
      int_valid <= next_int_valid;
      int_result <= next_int_result;
      result_valid <= next_result_valid;
      result_mant <= next_result_mant;
      result_exp <= next_result_exp;
      overflow_key <= next_c;
      negative_flag <= next_neg;
      zero_match_flag <= next_zero;
      real_fault <= next_fault;
      exc_code <= next_exc;
    end
  end

  // ----------------------------------------
  // Assertions
  // ----------------------------------------
  default clocking cb @(posedge clk); endclocking
  default disable iff (reset);

  norm_form_a: assert property (result_valid |-> (result_mant == '0) ||
      (result_mant[MANT_W-1] != result_mant[MANT_W-2]))
    else $error("result not normalized");
  exp_over_a: assert property (result_valid && result_exp > EXP_MAX |->
      exc_code == FAU_EXC_OVER)
    else $error("exponent overflow not flagged");
  store_range_a: assert property (op_done && exc_code == FAU_EXC_STORE |->
      !store_valid && !result_valid && $stable(acc_mant[cur_sel]))
    else $error("store range error changed state");
  div_zero_a: assert property (op_done && (cur_key == OP_QUOT || cur_key == OP_WQUOT) &&
      b_m == '0 |-> exc_code == FAU_EXC_DIV0 && overflow_key)
    else $error("divide by zero missed");
  fault_gate_a: assert property (real_fault |-> op_done && exc_code != FAU_EXC_NONE &&
      $past(real_fault_enable))
    else $error("fault without enabled exception");
  keys_kept_a: assert property (op_done && (cur_key == OP_CMP || cur_key == OP_LOAD ||
      cur_key == OP_WIDEN || cur_key == OP_WSTORE) |-> $stable(overflow_key))
    else $error("overflow key changed");
  div_time_a: assert property (op_valid && !busy && (op_code & ~MEM_SEL_MASK) == OP_QUOT &&
      mem_operand[31:SGL_EXP_W] != '0 |-> ##51 op_done)
    else $error("divide latency wrong");
  int_range_a: assert property (op_done && exc_code == FAU_EXC_INT |->
      !int_valid && overflow_key)
    else $error("integer range error mishandled");
  flags_excl_a: assert property (op_done && cur_key == OP_CMP && zero_match_flag |->
      !negative_flag)
    else $error("equal and less both set");
  flags_kept_a: assert property (op_done && cur_key != OP_CMP && cur_key != OP_WCMP |->
      $stable(negative_flag) && $stable(zero_match_flag))
    else $error("condition flags changed");

  div_done_c: cover property (state == FAU_DIVIDE ##1 op_done);
  cmp_equal_c: cover property (op_done && cur_key == OP_CMP && zero_match_flag);
  fault_c: cover property (real_fault);

endmodule

// *** testbench/fau_op_source.sv ***
// Model of the instruction decoder and operand path that feeds the unit
`timescale 1ns/1ns
module fau_op_source (
  input  wire logic clk,
  input  wire logic busy,
  input  wire logic op_done,
  output logic      op_valid,
  output logic [7:0]  op_code,
  output logic [63:0] mem_operand,
  output logic [31:0] int_operand,
  output logic      real_fault_enable
);
  initial
  begin
    op_valid = 1'b0;
    op_code = 8'h00;
    mem_operand = 64'h0;
    int_operand = 32'h0;
    real_fault_enable = 1'b0;
  end

  // Holds the request until the accept edge; operands are scrambled after it
  // so that a design that samples late does not see stale values
  task automatic issue(input logic [7:0] c, input logic [63:0] m,
                       input logic [31:0] i, input logic fe, output int n);
    logic taken;
    taken = 1'b0;
    // The accept edge is the first cycle of the latency, as the unit counts it
    n = 1;
    op_code = c;
    mem_operand = m;
    int_operand = i;
    real_fault_enable = fe;
    op_valid = 1'b1;
    while (!taken)
    begin
      taken = (busy === 1'b0);
      @(posedge clk);
      #1;
    end
    op_valid = 1'b0;
    op_code = ~c;
    mem_operand = ~m;
    int_operand = ~i;
    while (op_done !== 1'b1 && n < 60)
    begin
      @(posedge clk);
      #1;
      n = n + 1;
    end
  endtask
endmodule

// *** testbench/testbench.sv ***
// Self-checking bench of the floating arithmetic unit
`timescale 1ns/1ns
module testbench;
  import fau_pkg::*;
  logic                     clk;
  logic                     reset;
  logic                     op_valid;
  logic [7:0]               op_code;
  logic [63:0]              mem_operand;
  logic [31:0]              int_operand;
  logic                     real_fault_enable;
  logic                     busy;
  logic                     op_done;
  logic                     store_valid;
  logic [63:0]              store_data;
  logic                     int_valid;
  logic [31:0]              int_result;
  logic                     result_valid;
  logic [MANT_W-1:0]        result_mant;
  logic signed [EXP_W-1:0]  result_exp;
  logic                     overflow_key;
  logic                     negative_flag;
  logic                     zero_match_flag;
  logic                     real_fault;
  fau_exc_t                 exc_code;
  logic [31:0]              iv;
  logic                     fe;
  int                       mismatches;
  int                       comparisons;

  fau_core u_fau_core (.clk(clk), .reset(reset), .op_valid(op_valid), .op_code(op_code),
    .mem_operand(mem_operand), .int_operand(int_operand),
    .real_fault_enable(real_fault_enable), .busy(busy), .op_done(op_done),
    .store_valid(store_valid), .store_data(store_data), .int_valid(int_valid),
    .int_result(int_result), .result_valid(result_valid), .result_mant(result_mant),
    .result_exp(result_exp), .overflow_key(overflow_key), .negative_flag(negative_flag),
    .zero_match_flag(zero_match_flag), .real_fault(real_fault), .exc_code(exc_code));

  fau_op_source u_fau_op_source (.clk(clk), .busy(busy), .op_done(op_done),
    .op_valid(op_valid), .op_code(op_code), .mem_operand(mem_operand),
    .int_operand(int_operand), .real_fault_enable(real_fault_enable));

  initial
  begin
    clk = 1'b0;
    forever #4 clk = ~clk;
  end

  task automatic ck(input logic [63:0] got, input logic [63:0] exp);
    comparisons++;
    if (got !== exp)
    begin
      mismatches++;
      $display("wrong value at %0t: got %h expected %h", $time, got, exp);
    end
  endtask

  task automatic op(input logic [7:0] c, input logic [63:0] m, input int lat = 2);
    int n;
    u_fau_op_source.issue(c, m, iv, fe, n);
    ck(n, lat);
    ck(busy, 1'b0);
  endtask

  task automatic res(input logic [47:0] m, input logic signed [EXP_W-1:0] e,
                     input logic [2:0] x);
    ck(result_valid, 1'b1);
    ck(result_mant, m);
    ck(result_exp, e);
    ck(exc_code, x);
  endtask

  task automatic t_load_keys();
    fe = 1'b1;
    op(8'h18, 64'h0);
    ck({result_valid, overflow_key, exc_code}, 5'b01100);
    ck(real_fault, 1'b1);
    fe = 1'b0;
    op(8'h00, 64'h4000_0002);
    ck({result_valid, exc_code}, 4'h0);
    op(8'h09, 64'h0);
    ck({store_valid, store_data}, 65'h1_4000_0000_0000_0002);
    ck(overflow_key, 1'b1);
  endtask

  task automatic t_arith();
    op(8'h0c, 64'h4000_0002);
    res(48'h4000_0000_0000, 18'sd3, 3'h0);
    ck(overflow_key, 1'b0);
    op(8'h10, 64'h4000_0000);
    res(48'h7000_0000_0000, 18'sd2, 3'h0);
    op(8'h14, 64'h4000_0002);
    res(48'h7000_0000_0000, 18'sd3, 3'h0);
    op(8'h18, 64'h4000_0002, 51);
    res(48'h7000_0000_0000, 18'sd2, 3'h0);
  endtask

  task automatic t_compare();
    op(8'h1a, 64'h0);
    op(8'h04, 64'h4000_0003);
    ck({negative_flag, zero_match_flag}, 2'b10);
    op(8'h04, 64'h7000_0002);
    ck({negative_flag, zero_match_flag}, 2'b01);
    op(8'h04, 64'h4000_0002);
    ck({negative_flag, zero_match_flag}, 2'b00);
    ck({result_valid, overflow_key}, 2'b01);
  endtask

  task automatic t_negate();
    op(8'h00, 64'h4000_0000);
    op(8'h40, 64'h0);
    res(48'h8000_0000_0000, -18'sd1, 3'h0);
    ck(overflow_key, 1'b0);
  endtask

  task automatic t_convert();
    iv = 32'h0000_0003;
    op(8'h45, 64'h0);
    res(48'h6000_0000_0000, 18'sd2, 3'h0);
    iv = 32'h0003_ffff;
    op(8'h42, 64'h0);
    res(48'h6000_0000_0000, 18'sd2, 3'h0);
    op(8'h43, 64'h0);
    ck({int_valid, int_result}, 33'h1_0000_0003);
    op(8'h41, 64'h0);
    ck({int_valid, int_result}, 33'h1_0003_0000);
    op(8'h00, 64'h4000_001e);
    op(8'h43, 64'h0);
    ck({int_valid, int_result}, 33'h1_2000_0000);
    op(8'h00, 64'h4000_001f);
    op(8'h43, 64'h0);
    ck({int_valid, overflow_key, exc_code}, 5'b01101);
    op(8'h00, 64'h4000_000f);
    op(8'h41, 64'h0);
    ck({int_valid, int_result}, 33'h1_4000_0000);
    op(8'h00, 64'h4000_0010);
    op(8'h41, 64'h0);
    ck({int_valid, exc_code}, 4'h5);
  endtask

  task automatic t_round_store();
    op(8'h01, 64'h4000_0180_0000_0000);
    ck({result_valid, exc_code}, 4'h0);
    op(8'h09, 64'h0);
    ck({store_valid, store_data}, 65'h1_4000_0180_0000_0000);
    op(8'h47, 64'h0);
    res(48'h4000_0200_0000, 18'sd0, 3'h0);
    op(8'h08, 64'h0);
    ck({store_valid, store_data}, 65'h1_0000_0000_4000_0200);
    op(8'h01, 64'h4000_00fe_0000_0005);
    op(8'h08, 64'h0);
    ck({store_valid, store_data}, 65'h1_0000_0000_4000_0005);
  endtask

  task automatic t_store_range();
    op(8'h01, 64'h4000_0000_0000_0080);
    op(8'h08, 64'h0);
    ck({store_valid, exc_code}, 4'h3);
    op(8'h09, 64'h0);
    ck({store_valid, store_data}, 65'h1_4000_0000_0000_0080);
    ck(overflow_key, 1'b1);
    op(8'h01, 64'h4000_0000_0000_ff7f);
    op(8'h08, 64'h0);
    ck({store_valid, exc_code}, 4'h3);
    op(8'h01, 64'h4000_0000_0000_007f);
    op(8'h08, 64'h0);
    ck({store_valid, store_data}, 65'h1_0000_0000_4000_007f);
  endtask

  task automatic t_exp_range();
    op(8'h01, 64'h4000_0000_0000_7f7e);
    op(8'h0d, 64'h4000_0000_0000_7f7e);
    res(48'h4000_0000_0000, 18'sd32639, 3'h0);
    op(8'h0d, 64'h4000_0000_0000_7f7f);
    res(48'h4000_0000_0000, 18'sd32640, 3'h1);
    ck({real_fault, overflow_key}, 2'b01);
    fe = 1'b1;
    op(8'h01, 64'h4000_0000_0000_8000);
    op(8'h15, 64'h4000_0000_0000_ff80);
    res(48'h4000_0000_0000, -18'sd32897, 3'h2);
    ck(real_fault, 1'b1);
    fe = 1'b0;
  endtask

  task automatic t_wide();
    op(8'h03, 64'h4000_0000_0001_0001);
    op(8'h0f, 64'h4000_0000_0001_0001);
    res(48'h4000_0000_0001, 18'sd2, 3'h0);
    op(8'h13, 64'h4000_0000_0000_0002);
    res(48'h4000_0000_0000, -18'sd44, 3'h0);
    op(8'h17, 64'h4000_0000_0000_0002);
    res(48'h4000_0000_0000, -18'sd43, 3'h0);
    op(8'h1b, 64'h4000_0000_0000_ffff, 51);
    res(48'h4000_0000_0000, -18'sd41, 3'h0);
    op(8'h07, 64'h4000_0000_0000_ffd7);
    ck({negative_flag, zero_match_flag}, 2'b01);
    op(8'h0b, 64'h0);
    ck({store_valid, store_data}, 65'h1_4000_0000_0000_ffd7);
    op(8'h03, 64'h6000_0003_ffff_0001);
    op(8'h1b, 64'h0);
    op(8'h4e, 64'h0);
    ck({result_valid, exc_code}, 4'h0);
    op(8'h0b, 64'h0);
    ck({store_valid, store_data}, 65'h1_6000_0002_0000_0001);
    ck(overflow_key, 1'b1);
    op(8'h6c, 64'h0);
    res(48'h9fff_fffe_0000, 18'sd1, 3'h0);
  endtask

  task automatic print_verdict();
    $display("comparisons %0d mismatches %0d", comparisons, mismatches);
    if (mismatches == 0 && comparisons > 0)
      $display("Run complete: PASS");
    else
      $display("Run complete: FAIL");
    $finish;
  endtask

  // Whole run needs about 220 cycles; a hang is cut far beyond that
  initial
  begin
    #100000;
    mismatches++;
    print_verdict();
  end

  initial
  begin
    reset = 1'b1;
    iv = 32'h0;
    fe = 1'b0;
    mismatches = 0;
    comparisons = 0;
    repeat (10) @(posedge clk);
    #1;
    reset = 1'b0;
    t_load_keys();
    t_arith();
    t_compare();
    t_negate();
    t_convert();
    t_round_store();
    t_store_range();
    t_exp_range();
    t_wide();
    print_verdict();
  end
endmodule
